//--- core/fuse_cfg.svh
// Constants of the fuse store: layout, defaults, fields, geometry.
// Assumes inclusion by bare name from the package only.
`ifndef FUSE_CFG_SVH
`define FUSE_CFG_SVH

// ****************************************************************
// Store layout (byte index inside the non-volatile store)
// ****************************************************************
`define CFG_IDX_LOCK   3'h0
`define CFG_IDX_EXT    3'h1
`define CFG_IDX_HIGH   3'h2
`define CFG_IDX_LOW    3'h3
`define CFG_IDX_CAL    3'h4
`define CFG_IDX_SIG0   3'h5
`define CFG_WALK_FUSE  3'h3
`define CFG_WALK_CAL   3'h4

// ****************************************************************
// Factory values, 1 = unprogrammed
// ****************************************************************
`define CFG_ERASED     8'hFF
`define CFG_LOCK_USED  8'h03
`define CFG_EXT_USED   8'h01
`define CFG_HIGH_DFLT  8'hDF
`define CFG_LOW_DFLT   8'h64

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_LB_LOW     0
`define CFG_LB_HIGH    1
`define CFG_HI_KEEP    6
`define CFG_HI_SERIAL  5
`define CFG_LO_SRC_H   3
`define CFG_LO_SRC_L   0
`define CFG_SRC_RC8M   4'h4

// ****************************************************************
// CPU configuration pointer values
// ****************************************************************
`define CFG_Z_LOW      16'h0000
`define CFG_Z_LOCK     16'h0001
`define CFG_Z_EXT      16'h0002
`define CFG_Z_HIGH     16'h0003

// ****************************************************************
// Page geometry
// ****************************************************************
`define CFG_PC_TOP     9
`define CFG_PC_WORD_H  3
`define CFG_EE_TOP     6
`define CFG_EE_BYTE_H  1

`endif

//--- core/fuse_pkg.sv
// Types of the fuse, lock and signature store.
// Assumes fuse_cfg.svh is on the include path.
package fuse_pkg;
  `include "fuse_cfg.svh"

  // Programmer command byte
  typedef enum logic [7:0] {
    CMD_ERASE     = 8'b1000_0000,
    CMD_WR_FUSE   = 8'b0100_0000,
    CMD_WR_LOCK   = 8'b0010_0000,
    CMD_WR_FLASH  = 8'b0001_0000,
    CMD_WR_EEPROM = 8'b0001_0001,
    CMD_RD_SIG    = 8'b0000_1000,
    CMD_RD_FUSE   = 8'b0000_0100,
    CMD_RD_FLASH  = 8'b0000_0010,
    CMD_RD_EEPROM = 8'b0000_0011
  } prog_cmd_t;

  // Controller states
  typedef enum logic [2:0] {
    ST_LOAD  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_RESP  = 3'b011,
    ST_ERASE = 3'b100
  } ctrl_state_t;
endpackage : fuse_pkg

//--- core/config_nv_store.sv
// Small non-volatile byte store: one write port, one registered read port.
// Assumes no reset: contents survive rst_i; init_i loads a factory image.
`timescale 1ns/1ps
`default_nettype none
module config_nv_store #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int W     = 8
) (
  // Clock
  input  wire logic               clk_sys_i,
  // Factory image load
  input  wire logic               init_i,
  input  wire logic [DEPTH*W-1:0] init_image_i,
  // Write port
  input  wire logic               we_i,
  input  wire logic [AW-1:0]      waddr_i,
  input  wire logic [W-1:0]       wdata_i,
  // Read port
  input  wire logic [AW-1:0]      raddr_i,
  output logic      [W-1:0]       rdata_o
);
  logic [W-1:0] mem_q [DEPTH];  // Stored bytes

  // Depth must fit the address width
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("config_nv_store: DEPTH exceeds address range");
  end

  // One writer per entry; the factory image wins over a port write
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_sys_i) begin
      if (init_i) begin
        mem_q[i] <= init_image_i[i*W +: W];
      end else if (we_i && (waddr_i == AW'(i))) begin
        mem_q[i] <= wdata_i;
      end
    end
  end

  // Registered read, every cycle
  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem_q[raddr_i];
  end
endmodule : config_nv_store
`default_nettype wire

//--- core/fuse_lock_config_store.sv
// Lock bits, fuse bytes, signature and calibration byte of the device,
// with latching of fuse values, chip-erase sequencing and page geometry.
// Assumes the programming protocol engine and CPU run on clk_sys_i.
// Functional notes
// RULE1: two lock bits, only erase sets them
// RULE2: mode 1 applies no locking
// RULE3: mode 2 refuses programming, locks fuses
// RULE4: mode 3 also refuses verification readback
// RULE5: programmer writes fuses before lock bits
// RULE6: three fuse bytes, programmed reads zero
// RULE7: extended bit 0 gates self programming
// RULE8: high fuse byte field map
// RULE9: serial enable fuse hidden in serial mode
// RULE10: keep fuse saves EEPROM on erase
// RULE11: low fuse byte field map
// RULE12: source 0100 selects 8 MHz RC
// RULE13: chip erase leaves fuses unchanged
// RULE14: fuses latched on programming mode entry
// RULE15: keep fuse acts at once
// RULE16: fuses latched at power-up
// RULE17: signature readable even when locked
// RULE18: calibration byte in signature space
// RULE19: calibration copied to trim every reset
// RULE20: flash 64 pages of 16 words
// RULE21: EEPROM 32 pages of 4 bytes
// RULE22: CPU pointer selects lock or fuse
// RULE23: lock bits reset after flash erased
// RULE24: unused lock and extended bits read 1
`timescale 1ns/1ps
`default_nettype none
module fuse_lock_config_store
  import fuse_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h11,  // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h22,  // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h33,  // Arbitrary identity value
  parameter logic [7:0] CAL_DFLT  = 8'h80   // Arbitrary factory trim
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  // Factory image load
  input  wire logic       factory_init_i,
  // Programmer command port
  input  wire logic       prog_mode_i,
  input  wire logic       prog_serial_i,
  input  wire logic       cmd_valid_i,
  input  wire prog_cmd_t  cmd_code_i,
  input  wire logic [1:0] cmd_sel_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            cmd_ready_o,
  output logic            cmd_refused_o,
  output logic            prog_rvalid_o,
  output logic [7:0]      prog_rdata_o,
  // Chip erase handshake with the memories
  output logic            flash_erase_start_o,
  input  wire logic       flash_erase_done_i,
  output logic            eeprom_erase_o,
  // CPU configuration read
  input  wire logic       cpu_rd_i,
  input  wire logic [15:0] cpu_z_i,
  output logic            cpu_rd_ready_o,
  output logic            cpu_rvalid_o,
  output logic [7:0]      cpu_rdata_o,
  // Live and latched configuration
  output logic            core_hold_o,
  output logic [1:0]      protection_mode_o,
  output logic            flash_write_allow_o,
  output logic            mem_verify_allow_o,
  output logic [7:0]      fuse_extended_o,
  output logic [7:0]      fuse_high_o,
  output logic [7:0]      fuse_low_o,
  output logic            eeprom_keep_on_erase_o,
  output logic            internal_rc_8mhz_o,
  output logic [7:0]      oscillator_trim_register_o,
  // Page geometry
  input  wire logic [9:0] flash_pc_i,
  input  wire logic [6:0] eeprom_addr_i,
  output logic [3:0]      word_in_page_index_o,
  output logic [5:0]      flash_page_index_o,
  output logic [1:0]      eeprom_byte_index_o,
  output logic [4:0]      eeprom_page_index_o
);
  import fuse_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ctrl_state_t state_q;          // Controller state
  logic [2:0]  walk_q;           // Next store index to load
  logic        walk_cal_q;       // Walk also loads calibration
  logic        cap_v_q;          // Store read data is a walk byte
  logic [2:0]  cap_idx_q;        // Index of that byte
  logic        relatch_q;        // Mode edge waits for a walk
  logic        mode_q;           // Programming mode, last cycle
  logic [7:0]  lock_q;           // Live lock byte
  logic [7:0]  high_live_q;      // Live high fuse byte
  logic [7:0]  ext_lat_q;        // Latched fuse bytes
  logic [7:0]  high_lat_q;
  logic [7:0]  low_lat_q;
  logic [7:0]  trim_q;           // Oscillator trim
  logic        rd_cpu_q;         // Pending read belongs to the CPU
  logic        rd_fuse_q;        // Pending read is a fuse or lock byte
  logic [2:0]  rd_idx_q;         // Pending read index
  logic        rd_none_q;        // CPU pointer hit no byte
  logic        erase_go_q;       // First erase cycle
  logic [7:0]  store_rdata;      // Store read data
  logic [2:0]  raddr;            // Store read address
  logic        we;               // Store write
  logic [2:0]  waddr;
  logic [7:0]  wdata;
  logic        take_cmd;         // Command taken this cycle
  logic        take_cpu;         // CPU read taken this cycle
  logic        mode_edge;        // Programming mode entry or exit
  logic        fuse_locked;      // Lower lock bit programmed
  logic        verify_locked;    // Both lock bits programmed
  logic [2:0]  cmd_idx;          // Byte addressed by the command
  logic [2:0]  cpu_idx;          // Byte addressed by the pointer
  logic        cpu_hit;          // Pointer names a byte
  logic [7:0]  rd_masked;        // Read data after masking
  logic [63:0] factory_image;    // Initial store contents

  // Each byte keeps its factory value; index order follows the layout
  assign factory_image = {SIG_BYTE2, SIG_BYTE1, SIG_BYTE0, CAL_DFLT,
                          `CFG_LOW_DFLT, `CFG_HIGH_DFLT, `CFG_ERASED,
                          `CFG_ERASED};

  // ****************************************************************
  // Store
  // ****************************************************************
  config_nv_store #(.DEPTH(8), .AW(3), .W(8)) u_store (
    .clk_sys_i    (clk_sys_i),
    .init_i       (factory_init_i),
    .init_image_i (factory_image),
    .we_i         (we),
    .waddr_i      (waddr),
    .wdata_i      (wdata),
    .raddr_i      (raddr),
    .rdata_o      (store_rdata)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  // RULE3: lower lock bit locks fuses
  assign fuse_locked   = !lock_q[`CFG_LB_LOW];
  // RULE4: both bits block readback
  assign verify_locked = !lock_q[`CFG_LB_LOW] && !lock_q[`CFG_LB_HIGH];
  assign cmd_ready_o    = (state_q == ST_IDLE) && !rst_i && !mode_edge && !relatch_q;
  assign cpu_rd_ready_o = cmd_ready_o && !cmd_valid_i;
  assign take_cmd       = cmd_valid_i && cmd_ready_o;
  assign take_cpu       = cpu_rd_i && cpu_rd_ready_o;
  assign core_hold_o = (state_q == ST_LOAD) || rst_i;
  assign mode_edge   = prog_mode_i != mode_q;

  // Selector: fuse commands 0 low 1 lock 2 ext 3 high, signature 0..2 and cal
  always_comb begin
    cmd_idx = `CFG_IDX_LOW;
    if (cmd_code_i == CMD_RD_SIG) begin
      cmd_idx = (cmd_sel_i == 2'h3) ? `CFG_IDX_CAL : `CFG_IDX_SIG0 + 3'(cmd_sel_i);
    end else begin
      case (cmd_sel_i)
        2'h1:    cmd_idx = `CFG_IDX_LOCK;
        2'h2:    cmd_idx = `CFG_IDX_EXT;
        2'h3:    cmd_idx = `CFG_IDX_HIGH;
        default: cmd_idx = `CFG_IDX_LOW;
      endcase
    end
  end

  // RULE22: pointer to configuration byte
  always_comb begin
    cpu_hit = 1'b1;
    case (cpu_z_i)
      `CFG_Z_LOW:  cpu_idx = `CFG_IDX_LOW;
      `CFG_Z_LOCK: cpu_idx = `CFG_IDX_LOCK;
      `CFG_Z_EXT:  cpu_idx = `CFG_IDX_EXT;
      `CFG_Z_HIGH: cpu_idx = `CFG_IDX_HIGH;
      default: begin
        cpu_idx = `CFG_IDX_LOW;
        cpu_hit = 1'b0;
      end
    endcase
  end

  // Store read address: walk, then new requests
  always_comb begin
    if (state_q == ST_LOAD) begin
      raddr = walk_q;
    end else if (take_cmd) begin
      raddr = cmd_idx;
    end else if (take_cpu) begin
      raddr = cpu_idx;
    end else begin
      raddr = rd_idx_q;
    end
  end

  // ****************************************************************
  // Store writes
  // ****************************************************************
  // Lock commands only ever clear bits that the mask allows; fuse writes can set bits too
  always_comb begin
    we    = 1'b0;
    waddr = cmd_idx;
    wdata = cmd_data_i;
    if (state_q == ST_ERASE && !erase_go_q && flash_erase_done_i) begin
      // RULE23: lock reset after flash erase
      we    = 1'b1;
      waddr = `CFG_IDX_LOCK;
      wdata = `CFG_ERASED;
    end else if (take_cmd && cmd_code_i == CMD_WR_LOCK) begin
      // RULE1: lock bits only program to 0
      we    = 1'b1;
      waddr = `CFG_IDX_LOCK;
      // RULE24: unused lock bits stay 1
      wdata = (lock_q & cmd_data_i) | ~`CFG_LOCK_USED;
    end else if (take_cmd && cmd_code_i == CMD_WR_FUSE && !fuse_locked
                 && cmd_sel_i != 2'h1) begin
      we = 1'b1;
      if (cmd_sel_i == 2'h2) begin
        // RULE24: unused extended bits stay 1
        wdata = cmd_data_i | ~`CFG_EXT_USED;
      end else if (cmd_sel_i == 2'h3 && prog_serial_i) begin
        // RULE9: serial enable kept in serial mode
        wdata[`CFG_HI_SERIAL] = high_live_q[`CFG_HI_SERIAL];
      end
    end
  end

  // ****************************************************************
  // Controller
  // ****************************************************************
  // Walks run at reset release and on every programming mode edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q    <= ST_LOAD;
      walk_q     <= `CFG_IDX_LOCK;
      walk_cal_q <= 1'b1;
      erase_go_q <= 1'b0;
    end else begin
      erase_go_q <= 1'b0;
      case (state_q)
        // RULE16: latch at power-up
        ST_LOAD: begin
          walk_q <= walk_q + 3'h1;
          if (walk_q == (walk_cal_q ? `CFG_WALK_CAL : `CFG_WALK_FUSE)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (relatch_q || mode_edge) begin
            // RULE14: relatch on mode entry and exit
            state_q    <= ST_LOAD;
            walk_q     <= `CFG_IDX_LOCK;
            walk_cal_q <= 1'b0;
          end else if (take_cmd && cmd_code_i == CMD_ERASE) begin
            state_q    <= ST_ERASE;
            erase_go_q <= 1'b1;
          end else if (take_cpu || (take_cmd && (cmd_code_i == CMD_RD_SIG
                                    || cmd_code_i == CMD_RD_FUSE))) begin
            state_q <= ST_READ;
          end
        end
        ST_READ:  state_q <= ST_RESP;
        ST_RESP:  state_q <= ST_IDLE;
        ST_ERASE: begin
          if (!erase_go_q && flash_erase_done_i) begin
            state_q <= ST_IDLE;
          end
        end
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Mode edge seen while busy is kept; in ST_IDLE the flag clears and an edge there starts its walk directly
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_q    <= 1'b0;
      relatch_q <= 1'b0;
    end else begin
      mode_q <= prog_mode_i;
      if (mode_edge && state_q != ST_IDLE) begin
        relatch_q <= 1'b1;
      end else if (state_q == ST_IDLE) begin
        relatch_q <= 1'b0;
      end
    end
  end

  // Walk capture marks the byte the store returns next cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cap_v_q   <= 1'b0;
      cap_idx_q <= `CFG_IDX_LOCK;
    end else begin
      cap_v_q   <= state_q == ST_LOAD;
      cap_idx_q <= walk_q;
    end
  end

  // ****************************************************************
  // Live and latched configuration
  // ****************************************************************
  // Live copies follow store writes except in the cycle after a walk, when capture wins; latched ones change only on walks
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lock_q      <= `CFG_ERASED;
      high_live_q <= `CFG_HIGH_DFLT;
    end else if (cap_v_q) begin
      if (cap_idx_q == `CFG_IDX_LOCK) lock_q <= store_rdata;
      if (cap_idx_q == `CFG_IDX_HIGH) high_live_q <= store_rdata;
    end else if (we) begin
      if (waddr == `CFG_IDX_LOCK) lock_q <= wdata;
      // RULE15: keep fuse takes effect at once
      if (waddr == `CFG_IDX_HIGH) high_live_q <= wdata;
    end
  end

  // RULE6: latched bytes, 0 means programmed
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_lat_q  <= `CFG_ERASED;
      high_lat_q <= `CFG_HIGH_DFLT;
      low_lat_q  <= `CFG_LOW_DFLT;
    end else if (cap_v_q) begin
      if (cap_idx_q == `CFG_IDX_EXT)  ext_lat_q  <= store_rdata;
      if (cap_idx_q == `CFG_IDX_HIGH) high_lat_q <= store_rdata;
      if (cap_idx_q == `CFG_IDX_LOW)  low_lat_q  <= store_rdata;
    end
  end

  // RULE19: calibration to trim on reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      trim_q <= CAL_DFLT;
    end else if (cap_v_q && cap_idx_q == `CFG_IDX_CAL) begin
      // RULE18: calibration byte in store
      trim_q <= store_rdata;
    end
  end

  // ****************************************************************
  // Reads
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_cpu_q  <= 1'b0;
      rd_fuse_q <= 1'b0;
      rd_idx_q  <= `CFG_IDX_LOW;
      rd_none_q <= 1'b0;
    end else if (take_cmd) begin
      rd_cpu_q  <= 1'b0;
      rd_fuse_q <= cmd_code_i == CMD_RD_FUSE;
      rd_idx_q  <= cmd_idx;
      rd_none_q <= 1'b0;
    end else if (take_cpu) begin
      rd_cpu_q  <= 1'b1;
      rd_fuse_q <= 1'b1;
      rd_idx_q  <= cpu_idx;
      rd_none_q <= !cpu_hit;
    end
  end

  // Read mask: hidden serial enable and empty pointer read as 1
  always_comb begin
    rd_masked = store_rdata;
    // RULE24: unused bits read 1
    if (rd_fuse_q && rd_idx_q == `CFG_IDX_LOCK) rd_masked = store_rdata | ~`CFG_LOCK_USED;
    if (rd_fuse_q && rd_idx_q == `CFG_IDX_EXT)  rd_masked = store_rdata | ~`CFG_EXT_USED;
    // RULE9: serial enable hidden in serial mode
    if (!rd_cpu_q && rd_fuse_q && prog_serial_i && rd_idx_q == `CFG_IDX_HIGH) begin
      rd_masked[`CFG_HI_SERIAL] = 1'b1;
    end
    if (rd_none_q) rd_masked = `CFG_ERASED;
  end

  // RULE17: signature reads ignore lock bits
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prog_rvalid_o <= 1'b0;
      prog_rdata_o  <= 8'h00;
      cpu_rvalid_o  <= 1'b0;
      cpu_rdata_o   <= 8'h00;
    end else begin
      prog_rvalid_o <= (state_q == ST_READ) && !rd_cpu_q;
      cpu_rvalid_o  <= (state_q == ST_READ) && rd_cpu_q;
      if (state_q == ST_READ && !rd_cpu_q) prog_rdata_o <= rd_masked;
      if (state_q == ST_READ && rd_cpu_q)  cpu_rdata_o  <= rd_masked;
    end
  end

  // ****************************************************************
  // Refusal and erase pulses
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cmd_refused_o       <= 1'b0;
      flash_erase_start_o <= 1'b0;
      eeprom_erase_o      <= 1'b0;
    end else begin
      cmd_refused_o <= 1'b0;
      if (take_cmd) begin
        case (cmd_code_i)
          // RULE3: fuse writes refused when locked
          CMD_WR_FUSE:   cmd_refused_o <= fuse_locked || cmd_sel_i == 2'h1;
          CMD_WR_FLASH,
          CMD_WR_EEPROM: cmd_refused_o <= fuse_locked;
          // RULE4: readback refused in mode 3
          CMD_RD_FLASH,
          CMD_RD_EEPROM: cmd_refused_o <= verify_locked;
          default:       cmd_refused_o <= 1'b0;
        endcase
      end
      // RULE13: erase never writes fuses
      flash_erase_start_o <= take_cmd && cmd_code_i == CMD_ERASE;
      // RULE10: EEPROM erased unless keep programmed
      eeprom_erase_o <= take_cmd && cmd_code_i == CMD_ERASE
                        && high_live_q[`CFG_HI_KEEP];
    end
  end

  // ****************************************************************
  // Configuration outputs and geometry
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      protection_mode_o      <= 2'h1;
      flash_write_allow_o    <= 1'b1;
      mem_verify_allow_o     <= 1'b1;
      eeprom_keep_on_erase_o <= 1'b0;
      internal_rc_8mhz_o     <= 1'b1;
    end else begin
      // RULE2: mode 1 unlocked
      protection_mode_o   <= verify_locked ? 2'h3 : (fuse_locked ? 2'h2 : 2'h1);
      flash_write_allow_o <= !fuse_locked;
      mem_verify_allow_o  <= !verify_locked;
      eeprom_keep_on_erase_o <= !high_live_q[`CFG_HI_KEEP];
      // RULE12: 0100 selects internal RC
      internal_rc_8mhz_o <= low_lat_q[`CFG_LO_SRC_H:`CFG_LO_SRC_L] == `CFG_SRC_RC8M;
    end
  end

  // RULE7: extended bit 0 gates self programming
  // RULE8: high byte fields from latched copy
  // RULE11: low byte fields from latched copy
  assign fuse_extended_o            = ext_lat_q;
  assign fuse_high_o                = high_lat_q;
  assign fuse_low_o                 = low_lat_q;
  assign oscillator_trim_register_o = trim_q;

  // Geometry splits are registered, one cycle behind their inputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      word_in_page_index_o <= 4'h0;
      flash_page_index_o   <= 6'h00;
      eeprom_byte_index_o  <= 2'h0;
      eeprom_page_index_o  <= 5'h00;
    end else begin
      // RULE20: flash word and page split
      word_in_page_index_o <= flash_pc_i[`CFG_PC_WORD_H:0];
      flash_page_index_o   <= flash_pc_i[`CFG_PC_TOP:`CFG_PC_WORD_H+1];
      // RULE21: EEPROM byte and page split
      eeprom_byte_index_o  <= eeprom_addr_i[`CFG_EE_BYTE_H:0];
      eeprom_page_index_o  <= eeprom_addr_i[`CFG_EE_TOP:`CFG_EE_BYTE_H+1];
    end
  end
endmodule : fuse_lock_config_store
`default_nettype wire

//--- tb/flash_erase_model.sv
// Flash array stand-in: answers an erase start with done after a delay.
// Assumes start is a one-cycle pulse on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module flash_erase_model #(
  parameter int DLY = 9  // Array erase cycles, kept short
) (
  input  wire logic clk_sys_i,
  input  wire logic start_i,
  output logic      done_o
);
  int cnt_q = 0;  // Cycles left of the erase
  // Done for one cycle, when the count reaches 1
  always_ff @(posedge clk_sys_i) begin
    cnt_q <= start_i ? DLY : (cnt_q > 0 ? cnt_q - 1 : 0);
  end
  assign done_o = (cnt_q == 1);
endmodule : flash_erase_model
`default_nettype wire

//--- tb/fuse_store_monitor.sv
// Port checker of the fuse store.
// Assumes it is bound into fuse_lock_config_store.
`timescale 1ns/1ps
`default_nettype none
module fuse_store_monitor
  import fuse_pkg::*;
(
  input wire logic       clk_sys_i, rst_i, cmd_valid_i, cmd_ready_o, prog_rvalid_o,
  input wire prog_cmd_t  cmd_code_i,
  input wire logic       flash_erase_start_o, eeprom_erase_o, flash_write_allow_o,
  input wire logic       mem_verify_allow_o, internal_rc_8mhz_o,
  input wire logic [1:0] protection_mode_o, eeprom_byte_index_o,
  input wire logic [7:0] fuse_extended_o, fuse_low_o,
  input wire logic [9:0] flash_pc_i,
  input wire logic [6:0] eeprom_addr_i,
  input wire logic [3:0] word_in_page_index_o,
  input wire logic [5:0] flash_page_index_o,
  input wire logic [4:0] eeprom_page_index_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence rd_take; cmd_valid_i && cmd_ready_o && cmd_code_i == CMD_RD_FUSE; endsequence
  sequence rd_reply; !prog_rvalid_o ##1 prog_rvalid_o; endsequence
  fuse_read_a: assert property (rd_take |=> rd_reply) else $error("read late");
  flash_geom_a: assert property (!$past(rst_i) |->
    {flash_page_index_o, word_in_page_index_o} == $past(flash_pc_i)) else $error("flash geom");
  ee_geom_a: assert property (!$past(rst_i) |->
    {eeprom_page_index_o, eeprom_byte_index_o} == $past(eeprom_addr_i)) else $error("ee geom");
  keep_erase_a: assert property (eeprom_erase_o |-> flash_erase_start_o) else $error("ee erase");
  mode_free_a: assert property (protection_mode_o == 2'd1 |->
    flash_write_allow_o && mem_verify_allow_o) else $error("mode 1");
  mode_two_a: assert property (protection_mode_o == 2'd2 |->
    !flash_write_allow_o && mem_verify_allow_o) else $error("mode 2");
  mode_three_a: assert property (protection_mode_o == 2'd3 |->
    !flash_write_allow_o && !mem_verify_allow_o) else $error("mode 3");
  rc_select_a: assert property (internal_rc_8mhz_o == ($past(fuse_low_o[3:0]) == 4'h4))
    else $error("rc select");
  ext_unused_a: assert property (fuse_extended_o[7:1] == 7'h7f) else $error("ext bits");
endmodule : fuse_store_monitor
bind fuse_lock_config_store fuse_store_monitor u_mon (.*);
`default_nettype wire

//--- tb/test_fuse_lock_config_store.sv
// Bench of the fuse store: programmer and CPU traffic against fixed expected bytes.
// Assumes the erase model stands in for the flash array.
`timescale 1ns/1ps
`default_nettype none
module test_fuse_lock_config_store;
  import fuse_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, factory_init_i = 1, prog_mode_i = 0, prog_serial_i = 0;
  logic cmd_valid_i = 0, cpu_rd_i = 0, flash_erase_done_i, f;
  logic cmd_ready_o, cmd_refused_o, prog_rvalid_o, flash_erase_start_o, eeprom_erase_o;
  logic cpu_rd_ready_o, cpu_rvalid_o, core_hold_o, flash_write_allow_o, mem_verify_allow_o;
  logic eeprom_keep_on_erase_o, internal_rc_8mhz_o;
  logic [1:0] cmd_sel_i = 0, protection_mode_o, eeprom_byte_index_o;
  logic [7:0] cmd_data_i = 0, prog_rdata_o, cpu_rdata_o, fuse_extended_o, fuse_high_o;
  logic [7:0] fuse_low_o, oscillator_trim_register_o, r, nl, zv[5];
  logic [15:0] cpu_z_i = 0;
  logic [9:0] flash_pc_i = 0;
  logic [6:0] eeprom_addr_i = 0;
  logic [3:0] word_in_page_index_o;
  logic [5:0] flash_page_index_o;
  logic [4:0] eeprom_page_index_o;
  prog_cmd_t cmd_code_i = CMD_RD_FUSE;
  int errors = 0, cmp_count = 0;
  fuse_lock_config_store dut (.*);
  flash_erase_model u_fl (.clk_sys_i, .start_i(flash_erase_start_o), .done_o(flash_erase_done_i));
  always #12.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // One request, held until taken, then three cycles of answer capture
  task automatic op(bit cpu, prog_cmd_t c, logic [15:0] s, logic [7:0] d);
    int i = 0;
    {cmd_code_i, cmd_sel_i, cmd_data_i, cpu_z_i, cpu_rd_i, cmd_valid_i} = {c, s[1:0], d, s, cpu, !cpu};
    #1;
    while ((cpu ? cpu_rd_ready_o : cmd_ready_o) !== 1'b1 && i < 60) begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
    if (i >= 60) chk("ready", 0, 1);
    if (i >= 60) end_of_test();
    @(posedge clk_sys_i);
    #1;
    {cpu_rd_i, cmd_valid_i} = 0;
    f = cmd_refused_o;
    repeat (3) begin
      @(posedge clk_sys_i);
      #1;
      {flash_pc_i, eeprom_addr_i} = $urandom;
      if (prog_rvalid_o | cpu_rvalid_o) r = cpu ? cpu_rdata_o : prog_rdata_o;
      f |= cmd_refused_o;
    end
  endtask : op
  initial begin
    nl = $urandom(32'hb6be_6da5);
    repeat (5) @(posedge clk_sys_i);
    #1;
    {rst_i, factory_init_i} = 0;
    zv = '{8'h64, 8'hFF, 8'hFF, 8'hDF, 8'hFF};
    for (int k = 0; k < 5; k++) begin
      op(1, CMD_RD_FUSE, k, 0);
      chk("cpu cfg", r, zv[k]);
    end
    chk("trim", oscillator_trim_register_o, 8'h80);
    prog_mode_i = 1;
    op(0, CMD_WR_FUSE, 0, nl);
    op(0, CMD_WR_FUSE, 3, 8'h9F);
    chk("keep", eeprom_keep_on_erase_o, 1);
    op(0, CMD_RD_FUSE, 0, 0);
    chk("low rd", r, nl);
    chk("low held", fuse_low_o, 8'h64);
    prog_serial_i = 1;
    op(0, CMD_RD_FUSE, 3, 0);
    chk("serial hi", r, 8'hBF);
    prog_mode_i = 0;
    op(0, CMD_RD_SIG, 0, 0);
    chk("sig0", r, 8'h11);
    chk("low new", fuse_low_o, nl);
    op(0, CMD_WR_LOCK, 0, 8'h02);
    chk("mode", protection_mode_o, 2);
    op(0, CMD_WR_FUSE, 0, 8'h00);
    chk("refused", f, 1);
    op(0, CMD_WR_LOCK, 0, 8'h00);
    op(0, CMD_WR_LOCK, 0, 8'hFF);
    chk("mode", protection_mode_o, 3);
    op(0, CMD_RD_SIG, 2, 0);
    chk("sig2", r, 8'h33);
    op(0, CMD_ERASE, 0, 0);
    op(1, CMD_RD_FUSE, 1, 0);
    chk("lock", r, 8'hFF);
    op(1, CMD_RD_FUSE, 0, 0);
    chk("low kept", r, nl);
    end_of_test();
  end
endmodule : test_fuse_lock_config_store
`default_nettype wire
